/* File: hdl/eia_pkg.sv */
// Purpose: shared constants of the event interrupt aggregator
// Assumes: 8-bit event codes on the event lane bus
// Notes:   code = {class[7:6], spare[5], level[4], index[3:0]}
package eia_pkg;
    // ------------------------------------------------------------------
    // event code layout
    // ------------------------------------------------------------------
    localparam int unsigned ID_W    = 8;
    localparam int unsigned IDX_W   = 4;
    localparam int unsigned N_ENT   = 16;
    localparam int unsigned CLS_HI  = 7;
    localparam int unsigned CLS_LO  = 6;
    localparam int unsigned LVL_BIT = 4;
    localparam int unsigned CNT_W   = 8;

    localparam logic [1:0] CLS_STATUS = 2'h0;
    localparam logic [1:0] CLS_MCAST  = 2'h1;
    localparam logic [1:0] CLS_COUNT  = 2'h2;
    localparam logic [1:0] CLS_RSVD   = 2'h3;

    // ------------------------------------------------------------------
    // routing of generated events
    // ------------------------------------------------------------------
    localparam logic [1:0] MC_A_CLS  = CLS_COUNT;
    localparam logic [1:0] MC_B_CLS  = CLS_STATUS;
    localparam logic [1:0] CNT_O_CLS = CLS_STATUS;

    // ------------------------------------------------------------------
    // reset values and count limits
    // ------------------------------------------------------------------
    localparam logic [ID_W-1:0]  ID_RST   = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST  = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
    localparam logic [CNT_W-1:0] CNT_MAX  = 8'hff;
    localparam logic [N_ENT-1:0] STAT_RST = 16'h0000;

    typedef enum logic [1:0] {
        EIA_ARB_MC  = 2'b00,
        EIA_ARB_CNT = 2'b01
    } eia_arb_t;
endpackage

/* File: hdl/eia_event_slot.sv */
// Purpose: one-entry holding slot for a generated event
// Assumes: consumer takes the event with out_ready_i
// Notes:   an event stays here unchanged until taken
`timescale 1ns/1ps
module eia_event_slot (
    input  wire logic                      clk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic                      in_valid_i,
    input  wire logic [eia_pkg::ID_W-1:0]  in_id_i,
    output logic                           in_ready_o,
    output logic                           out_valid_o,
    output logic [eia_pkg::ID_W-1:0]       out_id_o,
    input  wire logic                      out_ready_i
);
    logic                     full;
    logic                     next_full;
    logic [eia_pkg::ID_W-1:0] id;
    logic [eia_pkg::ID_W-1:0] next_id;

    always_comb begin
        next_full = full;
        next_id   = id;
        if (full && out_ready_i) begin
            next_full = 1'b0;
        end
        if (in_valid_i && !full) begin
            next_full = 1'b1;
            next_id   = in_id_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            full <= 1'b0;
            id   <= eia_pkg::ID_RST;
        end else begin
            full <= next_full;
            id   <= next_id;
        end
    end

    assign in_ready_o  = !full;
    assign out_valid_o = full;
    assign out_id_o    = id;
endmodule // eia_event_slot

/* File: hdl/eia_event_interrupt_aggregator.sv */
// Purpose: event interrupt aggregator with status, multicast and
//          counted processing blocks on the event lane bus
// Assumes: inputs synchronous to clk_i; single clock domain
// Notes:
`timescale 1ns/1ps
module eia_event_interrupt_aggregator (
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic                          ev_valid_i,
    input  wire logic [eia_pkg::ID_W-1:0]      ev_id_i,
    output logic                               ev_ready_o,
    output logic                               out_valid_o,
    output logic [eia_pkg::ID_W-1:0]           out_id_o,
    input  wire logic                          out_ready_i,
    output logic [eia_pkg::N_ENT-1:0]          irq_o,
    input  wire logic [eia_pkg::N_ENT-1:0]     status_clr_i,
    input  wire logic [eia_pkg::IDX_W-1:0]     cnt_sel_i,
    output logic [eia_pkg::CNT_W-1:0]          cnt_o,
    input  wire logic                          cnt_dec_i,
    input  wire logic [eia_pkg::IDX_W-1:0]     cnt_dec_idx_i,
    output logic                               cnt_dec_ack_o
);
    // ------------------------------------------------------------------
    // input decode
    // ------------------------------------------------------------------
    logic [1:0]                 cls;
    logic [eia_pkg::IDX_W-1:0]  idx;
    logic                       acc;
    logic                       st_take;
    logic                       mc_take;
    logic                       cnt_take;
    logic                       mca_rdy;
    logic                       mcb_rdy;
    logic                       cnt_rdy;

    assign cls = ev_id_i[eia_pkg::CLS_HI:eia_pkg::CLS_LO];
    assign idx = ev_id_i[eia_pkg::IDX_W-1:0];

    always_comb begin
        case (cls)
            eia_pkg::CLS_MCAST: ev_ready_o = mca_rdy && mcb_rdy;
            eia_pkg::CLS_COUNT: ev_ready_o = cnt_rdy;
            default:            ev_ready_o = 1'b1;
        endcase
    end

    assign acc      = ev_valid_i && ev_ready_o;
    assign st_take  = acc && (cls == eia_pkg::CLS_STATUS);
    assign mc_take  = acc && (cls == eia_pkg::CLS_MCAST);
    assign cnt_take = acc && (cls == eia_pkg::CLS_COUNT);

    // ------------------------------------------------------------------
    // status block
    // ------------------------------------------------------------------
    logic [eia_pkg::N_ENT-1:0] status;
    logic [eia_pkg::N_ENT-1:0] next_status;
    logic [eia_pkg::N_ENT-1:0] set_vec;

    always_comb begin
        set_vec = '0;
        if (st_take) begin
            set_vec[idx] = 1'b1;
        end
        // a set in the clearing cycle wins
        next_status = (status & ~status_clr_i) | set_vec;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status <= eia_pkg::STAT_RST;
        end else begin
            status <= next_status;
        end
    end

    assign irq_o = status;

    // ------------------------------------------------------------------
    // multicast block: two slots loaded together
    // ------------------------------------------------------------------
    logic                     mca_v;
    logic                     mcb_v;
    logic                     cnt_v;
    logic [eia_pkg::ID_W-1:0] mca_id;
    logic [eia_pkg::ID_W-1:0] mcb_id;
    logic [eia_pkg::ID_W-1:0] cnt_id;
    logic                     gnt_a;
    logic                     gnt_b;
    logic                     gnt_c;

    eia_event_slot u_slot_mca (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (mc_take),
        .in_id_i     ({eia_pkg::MC_A_CLS, 2'h0, idx}),
        .in_ready_o  (mca_rdy),
        .out_valid_o (mca_v),
        .out_id_o    (mca_id),
        .out_ready_i (gnt_a)
    );

    eia_event_slot u_slot_mcb (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (mc_take),
        .in_id_i     ({eia_pkg::MC_B_CLS, 2'h0, idx}),
        .in_ready_o  (mcb_rdy),
        .out_valid_o (mcb_v),
        .out_id_o    (mcb_id),
        .out_ready_i (gnt_b)
    );

    // ------------------------------------------------------------------
    // counted block
    // ------------------------------------------------------------------
    logic [eia_pkg::CNT_W-1:0] count      [eia_pkg::N_ENT];
    logic [eia_pkg::CNT_W-1:0] next_count [eia_pkg::N_ENT];
    logic                      dec_ack;
    logic                      up_ev;
    logic                      dn_ev;
    logic                      cnt_load;
    logic [eia_pkg::ID_W-1:0]  cnt_ev_id;
    logic [eia_pkg::CNT_W-1:0] next_cnt_o;

    // decrement only while no increment is taken and the slot is free
    assign dec_ack       = cnt_dec_i && cnt_rdy && !cnt_take;
    assign cnt_dec_ack_o = dec_ack;
    assign up_ev    = cnt_take && (count[idx] == eia_pkg::CNT_RST);
    assign dn_ev    = dec_ack && (count[cnt_dec_idx_i] == eia_pkg::CNT_ONE);
    assign cnt_load = up_ev || dn_ev;

    always_comb begin
        // class is fixed away from multicast, so no loop can form
        cnt_ev_id = {eia_pkg::CNT_O_CLS, 1'b0, up_ev,
                     up_ev ? idx : cnt_dec_idx_i};
        for (int i = 0; i < eia_pkg::N_ENT; i++) begin
            next_count[i] = count[i];
        end
        if (cnt_take && count[idx] != eia_pkg::CNT_MAX) begin
            next_count[idx] = count[idx] + eia_pkg::CNT_ONE;
        end
        if (dec_ack && count[cnt_dec_idx_i] != eia_pkg::CNT_RST) begin
            next_count[cnt_dec_idx_i] =
                count[cnt_dec_idx_i] - eia_pkg::CNT_ONE;
        end
        next_cnt_o = count[cnt_sel_i];
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < eia_pkg::N_ENT; i++) begin
                count[i] <= eia_pkg::CNT_RST;
            end
            cnt_o <= eia_pkg::CNT_RST;
        end else begin
            for (int i = 0; i < eia_pkg::N_ENT; i++) begin
                count[i] <= next_count[i];
            end
            cnt_o <= next_cnt_o;
        end
    end

    eia_event_slot u_slot_cnt (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (cnt_load),
        .in_id_i     (cnt_ev_id),
        .in_ready_o  (cnt_rdy),
        .out_valid_o (cnt_v),
        .out_id_o    (cnt_id),
        .out_ready_i (gnt_c)
    );

    // ------------------------------------------------------------------
    // output arbiter and register onto the event lane bus
    // ------------------------------------------------------------------
    eia_pkg::eia_arb_t        arb;
    eia_pkg::eia_arb_t        next_arb;
    logic                     out_v;
    logic                     next_out_v;
    logic [eia_pkg::ID_W-1:0] out_id;
    logic [eia_pkg::ID_W-1:0] next_out_id;
    logic                     load_out;

    assign load_out = !out_v || out_ready_i;

    always_comb begin
        gnt_a       = 1'b0;
        gnt_b       = 1'b0;
        gnt_c       = 1'b0;
        next_arb    = arb;
        next_out_v  = out_v && !out_ready_i;
        next_out_id = out_id;
        if (load_out) begin
            case (arb)
                eia_pkg::EIA_ARB_CNT: begin
                    if (cnt_v) begin
                        gnt_c = 1'b1;
                    end else if (mca_v) begin
                        gnt_a = 1'b1;
                    end else begin
                        gnt_b = mcb_v;
                    end
                end
                default: begin
                    if (mca_v) begin
                        gnt_a = 1'b1;
                    end else if (mcb_v) begin
                        gnt_b = 1'b1;
                    end else begin
                        gnt_c = cnt_v;
                    end
                end
            endcase
            if (gnt_c) begin
                next_arb = eia_pkg::EIA_ARB_MC;
            end else if (gnt_a || gnt_b) begin
                next_arb = eia_pkg::EIA_ARB_CNT;
            end
            if (gnt_a || gnt_b || gnt_c) begin
                next_out_v  = 1'b1;
                next_out_id = gnt_a ? mca_id : (gnt_b ? mcb_id : cnt_id);
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            arb    <= eia_pkg::EIA_ARB_MC;
            out_v  <= 1'b0;
            out_id <= eia_pkg::ID_RST;
        end else begin
            arb    <= next_arb;
            out_v  <= next_out_v;
            out_id <= next_out_id;
        end
    end

    assign out_valid_o = out_v;
    assign out_id_o    = out_id;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_status_sets_irq: assert property (
        st_take |=> irq_o[$past(idx)])
        else $error("status event did not raise its interrupt");

    a_mcast_two_out: assert property (
        mc_take |=> mca_v && mcb_v
            && mca_id[eia_pkg::IDX_W-1:0] == mcb_id[eia_pkg::IDX_W-1:0])
        else $error("multicast did not produce two events");

    a_count_incr: assert property (
        cnt_take && count[idx] != eia_pkg::CNT_MAX
        |=> count[$past(idx)] == $past(count[idx]) + eia_pkg::CNT_ONE)
        else $error("counted event not added to count");

    a_count_zero_edge: assert property (
        cnt_take && count[idx] != eia_pkg::CNT_RST |-> !cnt_load)
        else $error("counted block emitted without zero crossing");

    a_count_up_emit: assert property (
        cnt_take && count[idx] == eia_pkg::CNT_RST
        |=> cnt_v && cnt_id[eia_pkg::LVL_BIT])
        else $error("count leaving zero gave no event");

    a_out_has_source: assert property (
        $rose(out_valid_o) |-> $past(mca_v || mcb_v || cnt_v))
        else $error("bus event appeared without a source");

    a_stall_blocked: assert property (
        (!mca_rdy && cls == eia_pkg::CLS_MCAST)
        || (!cnt_rdy && cls == eia_pkg::CLS_COUNT) |-> !ev_ready_o)
        else $error("blocked block accepted an event");

    a_no_loop_route: assert property (
        cnt_v |-> cnt_id[eia_pkg::CLS_HI:eia_pkg::CLS_LO]
                  != eia_pkg::CLS_MCAST)
        else $error("counted output routed to multicast");

    a_hold_stable: assert property (
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_id_o))
        else $error("held bus event changed or dropped");

    c_mcast_pair: cover property (mc_take ##1 gnt_a ##1 gnt_b);
    c_cnt_up_down: cover property (up_ev ##[1:50] dn_ev);
    c_in_stall: cover property (ev_valid_i && !ev_ready_o);
    c_irq_set: cover property (st_take ##1 irq_o != '0);
endmodule // eia_event_interrupt_aggregator

/* File: tb/eia_sink_model.sv */
// Purpose: consumer of generated events on the far side of the output bus
// Assumes: ready changes only at the falling edge of clk_i
// Notes:   mode 0 stalls, 1 always takes, 2 takes when rnd_i is high
`timescale 1ns/1ps
module eia_sink_model (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [1:0] mode_i,
    input  wire logic       rnd_i,
    output logic            ready_o
);
    initial ready_o = 1'b0;

    // ------------------------------------------------------------------
    // take or stall
    // ------------------------------------------------------------------
    always @(negedge clk_i) begin
        ready_o <= !sys_rst_i && (mode_i == 2'h1 ||
                                  (mode_i == 2'h2 && rnd_i));
    end
endmodule // eia_sink_model

/* File: tb/test_event_interrupt_aggregator.sv */
// Purpose: self-checking bench of the event interrupt aggregator
// Assumes: status, multicast and counted phases drained apart
// Notes:   queue model predicts every generated event in order
`timescale 1ns/1ps
module test_event_interrupt_aggregator;
    logic                      clk_i         = 1'b0;
    logic                      sys_rst_i     = 1'b1;
    logic                      ev_valid_i    = 1'b0;
    logic [eia_pkg::ID_W-1:0]  ev_id_i       = 8'h00;
    logic                      ev_ready_o;
    logic                      out_valid_o;
    logic [eia_pkg::ID_W-1:0]  out_id_o;
    logic                      out_ready_i;
    logic [eia_pkg::N_ENT-1:0] irq_o;
    logic [eia_pkg::N_ENT-1:0] status_clr_i  = 16'h0000;
    logic [eia_pkg::IDX_W-1:0] cnt_sel_i     = 4'h0;
    logic [eia_pkg::CNT_W-1:0] cnt_o;
    logic                      cnt_dec_i     = 1'b0;
    logic [eia_pkg::IDX_W-1:0] cnt_dec_idx_i = 4'h0;
    logic                      cnt_dec_ack_o;
    logic [1:0]                mode          = 2'h1;
    logic [31:0]               seed          = 32'd96344;
    logic [31:0]               sink_s        = 32'd96344;
    logic [eia_pkg::N_ENT-1:0] st_m          = 16'h0000;
    int                        cnt_m [16]    = '{default: 0};
    logic [7:0]                exp_q [$];
    logic                      held          = 1'b0;
    logic [7:0]                held_id       = 8'h00;
    logic [7:0]                e;
    int                        n_errors      = 0;
    int                        tests_run     = 0;

    initial forever #2 clk_i = ~clk_i;

    eia_event_interrupt_aggregator DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ev_valid_i(ev_valid_i),
        .ev_id_i(ev_id_i), .ev_ready_o(ev_ready_o),
        .out_valid_o(out_valid_o), .out_id_o(out_id_o),
        .out_ready_i(out_ready_i), .irq_o(irq_o),
        .status_clr_i(status_clr_i), .cnt_sel_i(cnt_sel_i), .cnt_o(cnt_o),
        .cnt_dec_i(cnt_dec_i), .cnt_dec_idx_i(cnt_dec_idx_i),
        .cnt_dec_ack_o(cnt_dec_ack_o)
    );

    eia_sink_model u_sink (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_i(mode),
        .rnd_i(sink_s[3]), .ready_o(out_ready_i)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic summarize;
        $display("checks=%0d errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_up;
        check(16'h0000, 16'h0001);
        summarize();
    endtask

    task automatic send_ev(input logic [7:0] id);
        int n;
        @(negedge clk_i);
        ev_valid_i = 1'b1;
        ev_id_i    = id;
        for (n = 0; n < 400; n++) begin
            #1;
            if (ev_ready_o === 1'b1) break;
            @(negedge clk_i);
        end
        if (n == 400) give_up();
        @(posedge clk_i);
    endtask

    task automatic dec(input logic [3:0] idx);
        int n;
        @(negedge clk_i);
        cnt_dec_i     = 1'b1;
        cnt_dec_idx_i = idx;
        for (n = 0; n < 400; n++) begin
            #1;
            if (cnt_dec_ack_o === 1'b1) break;
            @(negedge clk_i);
        end
        if (n == 400) give_up();
        @(negedge clk_i);
        cnt_dec_i = 1'b0;
    endtask

    task automatic idle;
        @(negedge clk_i);
        ev_valid_i = 1'b0;
    endtask

    task automatic drain;
        int n;
        for (n = 0; n < 400; n++) begin
            @(negedge clk_i);
            if (exp_q.size() == 0 && out_valid_o === 1'b0) break;
        end
        if (n == 400) give_up();
    endtask

    task automatic chk_cnt(input logic [3:0] idx);
        @(negedge clk_i);
        cnt_sel_i = idx;
        repeat (3) @(negedge clk_i);
        check(cnt_o, cnt_m[idx][7:0]);
    endtask

    // ------------------------------------------------------------------
    // reference model and output monitor
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!sys_rst_i) begin
            e    = ev_id_i;
            st_m = st_m & ~status_clr_i;
            if (held) begin
                check(out_valid_o, 1'b1);
                check(out_id_o, held_id);
            end
            held    = out_valid_o && !out_ready_i;
            held_id = out_id_o;
            if (out_valid_o && out_ready_i) begin
                check(out_id_o[7:6] != 2'h1, 1'b1);
                if (exp_q.size() == 0) check(out_id_o, 16'h0100);
                else check(out_id_o, exp_q.pop_front());
            end
            if (cnt_dec_i && cnt_dec_ack_o) begin
                if (cnt_m[cnt_dec_idx_i] == 1)
                    exp_q.push_back({4'h0, cnt_dec_idx_i});
                if (cnt_m[cnt_dec_idx_i] > 0) cnt_m[cnt_dec_idx_i]--;
            end
            if (ev_valid_i && ev_ready_o) begin
                case (e[7:6])
                    2'h0: st_m[e[3:0]] = 1'b1;
                    2'h1: begin
                        exp_q.push_back({2'h2, 2'h0, e[3:0]});
                        exp_q.push_back({4'h0, e[3:0]});
                    end
                    2'h2: begin
                        if (cnt_m[e[3:0]] == 0) exp_q.push_back({4'h1, e[3:0]});
                        if (cnt_m[e[3:0]] < 255) cnt_m[e[3:0]]++;
                    end
                    default: ;
                endcase
            end
        end
    end

    always @(negedge clk_i) begin
        if (!sys_rst_i) check(irq_o, st_m);
    end

    // sink randomness moves every cycle so a stalled bus always frees
    always @(negedge clk_i) begin
        sink_s <= lfsr_next(sink_s);
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        for (int i = 0; i < 16; i++) send_ev({3'h0, i[0], i[3:0]});
        send_ev(8'hc5);
        idle();
        status_clr_i = 16'h00ff;
        send_ev(8'h03);
        idle();
        status_clr_i = 16'h0000;
        send_ev(8'h43);
        send_ev(8'h47);
        idle();
        drain();
        mode = 2'h0;
        send_ev(8'h49);
        @(negedge clk_i);
        ev_id_i = 8'h4a;
        repeat (3) @(negedge clk_i);
        #1 check(ev_ready_o, 1'b0);
        mode = 2'h1;
        send_ev(8'h4a);
        idle();
        drain();
        mode = 2'h0;
        // first up event fills the output stage, second one the slot
        send_ev(8'h82);
        send_ev(8'h83);
        @(negedge clk_i);
        ev_id_i = 8'h84;
        repeat (2) @(negedge clk_i);
        #1 check(ev_ready_o, 1'b0);
        mode = 2'h1;
        send_ev(8'h82);
        idle();
        repeat (3) dec(4'h2);
        drain();
        chk_cnt(4'h2);
        repeat (256) send_ev(8'h85);
        idle();
        drain();
        chk_cnt(4'h5);
        mode = 2'h2;
        repeat (400) begin
            seed = lfsr_next(seed);
            idle();
            status_clr_i = seed[23:8] & 16'h1111;
            cnt_sel_i    = seed[11:8];
            case (seed[1:0])
                2'h0: send_ev({2'h0, seed[7:2]});
                2'h1: send_ev({2'h2, seed[7:2]});
                2'h2: send_ev({2'h3, seed[7:2]});
                default: dec(seed[7:4]);
            endcase
        end
        idle();
        status_clr_i = 16'h0000;
        mode = 2'h1;
        drain();
        for (int i = 0; i < 16; i++) chk_cnt(i[3:0]);
        summarize();
    end
endmodule // test_event_interrupt_aggregator
